// ### hdl/fb_ratio_defs.svh
// Offsets, field positions, reset values and fixed counts of the feedback ratio registers.
`ifndef FB_RATIO_DEFS_SVH
`define FB_RATIO_DEFS_SVH

`define FB_ADDR_W 12
`define FB_OFS_FIXED_TERM_TOP 12'h10B
`define FB_OFS_DENOMINATOR_B0 12'h10C
`define FB_OFS_DENOMINATOR_B1 12'h10D
`define FB_OFS_DENOMINATOR_B2 12'h10E
`define FB_OFS_DENOMINATOR_B3 12'h10F
`define FB_OFS_REMAINDER_B0 12'h110
`define FB_OFS_REMAINDER_B1 12'h111
`define FB_OFS_REMAINDER_B2 12'h112
`define FB_OFS_REMAINDER_B3 12'h113
`define FB_OFS_TRUNCATE_POS 12'h114

`define FB_NUM_REGS 10
`define FB_IDX_W 4
`define FB_IDX_FIXED_TERM_TOP 4'h0
`define FB_IDX_DENOMINATOR_B0 4'h1
`define FB_IDX_REMAINDER_B0 4'h5
`define FB_IDX_TRUNCATE_POS 4'h9

`define FB_TOP_FIELD_MASK 8'h03
`define FB_FULL_FIELD_MASK 8'hFF

`define FB_RESET_IMAGE 80'h0000_0000_0000_0000_0100

`define FB_TERM_W 42
`define FB_TERM_LOW_W 40
`define FB_FRAC_BITS 33
`define FB_INT_BITS 9
`define FB_WORD_W 32
`define FB_TRUNC_MAX 8'h21
`define FB_DEN_ONE 32'h0000_0001

`endif

// ### hdl/fb_ratio_pkg.sv
// Types shared by the feedback ratio register bank.
package fb_ratio_pkg;

   typedef logic [7:0] reg_byte_t;

   typedef struct packed {
      logic term_zero;
      logic den_zero;
      logic trunc_invalid;
      logic den_not_one;
      logic rem_not_zero;
      logic low_bits_set;
   } cfg_status_t;

endpackage : fb_ratio_pkg

// ### hdl/fb_regfile_if.sv
// Port bundle between the register decode and the byte register store.
`timescale 1ns/100ps
`default_nettype none
`include "fb_ratio_defs.svh"

interface fb_regfile_if;
   logic wr_en;
   logic [`FB_IDX_W-1:0] wr_idx;
   logic [7:0] wr_data;
   logic [7:0] wr_mask;
   logic rd_en;
   logic rd_hit;
   logic [`FB_IDX_W-1:0] rd_idx;
   logic [7:0] rd_data;
   logic [`FB_NUM_REGS*8-1:0] contents;

   modport ctrl (output wr_en, wr_idx, wr_data, wr_mask, rd_en, rd_hit, rd_idx, input rd_data, contents);
   modport store (input wr_en, wr_idx, wr_data, wr_mask, rd_en, rd_hit, rd_idx, output rd_data, contents);
endinterface : fb_regfile_if

`default_nettype wire

// ### hdl/fb_byte_store.sv
// Byte-wide register store with masked writes and a registered read port.
`timescale 1ns/100ps
`default_nettype none
`include "fb_ratio_defs.svh"

module fb_byte_store #(
   parameter int NUM_REGS = `FB_NUM_REGS,
   parameter logic [`FB_NUM_REGS*8-1:0] RESET_IMAGE = `FB_RESET_IMAGE
) (
   input wire logic clk,            // Register clock.
   input wire logic rst_n,          // Asynchronous reset, active low.
   input wire logic clk_en,         // Freezes all state while low.
   fb_regfile_if.store port         // Write, read and contents bundle.
);

   logic [7:0] mem_r [NUM_REGS];
   logic [7:0] mem_nxt [NUM_REGS];
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_entry
         // Bits outside the write mask are unused and always hold zero.
         always_comb begin
            mem_nxt[g] = mem_r[g];
            if (port.wr_en && (int'(port.wr_idx) == g)) begin
               mem_nxt[g] = port.wr_data & port.wr_mask;
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               mem_r[g] <= RESET_IMAGE[g*8 +: 8];
            end else if (clk_en) begin
               mem_r[g] <= mem_nxt[g];
            end
         end

         assign port.contents[g*8 +: 8] = mem_r[g];
      end
   endgenerate

   // Unmapped reads return zero.
   always_comb begin
      rd_data_nxt = rd_data_r;
      if (port.rd_en) begin
         rd_data_nxt = port.rd_hit ? mem_r[port.rd_idx] : 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= 8'h00;
      end else if (clk_en) begin
         rd_data_r <= rd_data_nxt;
      end
   end

   assign port.rd_data = rd_data_r;

endmodule : fb_byte_store

`default_nettype wire

// ### hdl/pll_fractional_feedback_regs.sv
// Feedback ratio register bank of the synthesizer loop: fixed-point term top, denominator, remainder, truncation.
`timescale 1ns/100ps
`default_nettype none
`include "fb_ratio_defs.svh"

module pll_fractional_feedback_regs #(
   parameter int FRAC_BITS = `FB_FRAC_BITS,
   parameter int INT_BITS = `FB_INT_BITS
) (
   input wire logic clk,                                   // Register clock, 125 MHz.
   input wire logic rst_n,                                 // Asynchronous reset, active low.
   input wire logic clk_en,                                // Freezes all state while low.
   input wire logic [`FB_ADDR_W-1:0] reg_addr,             // Register byte address.
   input wire logic reg_wr,                                // Write strobe, one cycle.
   input wire logic [7:0] reg_wdata,                       // Write data.
   input wire logic reg_rd,                                // Read strobe, one cycle.
   output logic [7:0] reg_rdata,                           // Read data, registered.
   output logic reg_rvalid,                                // Read data valid, one cycle.
   input wire logic [`FB_TERM_LOW_W-1:0] fixed_term_low,   // Term bits 39:0 from the neighbouring registers.
   output logic [`FB_TERM_W-1:0] fb_fixed_point_term,      // Term seen by the divider, truncated bits cleared.
   output logic [`FB_WORD_W-1:0] fb_denominator,           // Denominator seen by the divider.
   output logic [`FB_WORD_W-1:0] fb_remainder,             // Remainder seen by the divider.
   output logic [7:0] fb_truncate_position,                // Truncate position in force, zero outside fractional form.
   output logic [7:0] fb_valid_frac_bits,                  // Count of valid fractional bits in force.
   output logic fb_fractional_form,                        // High when remainder over denominator is in use.
   output fb_ratio_pkg::cfg_status_t cfg_status            // Configuration consistency flags.
);

   fb_regfile_if rf ();

   fb_byte_store #(
      .NUM_REGS(`FB_NUM_REGS),
      .RESET_IMAGE(`FB_RESET_IMAGE)
   ) u_store (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .port(rf.store)
   );

   // Address decode: the bank occupies a dense run from the fixed-term top byte.
   logic addr_hit;
   logic [`FB_ADDR_W-1:0] addr_rel;

   always_comb begin
      addr_rel = reg_addr - `FB_OFS_FIXED_TERM_TOP;
      addr_hit = (reg_addr >= `FB_OFS_FIXED_TERM_TOP) && (reg_addr <= `FB_OFS_TRUNCATE_POS);
   end

   always_comb begin
      rf.wr_en = reg_wr && addr_hit;
      rf.wr_idx = addr_rel[`FB_IDX_W-1:0];
      rf.wr_data = reg_wdata;
      rf.wr_mask = `FB_FULL_FIELD_MASK;
      if (rf.wr_idx == `FB_IDX_FIXED_TERM_TOP) begin
         rf.wr_mask = `FB_TOP_FIELD_MASK;
      end
      rf.rd_en = reg_rd;
      rf.rd_hit = addr_hit;
      rf.rd_idx = addr_rel[`FB_IDX_W-1:0];
   end

   // Read answer follows the strobe by one cycle.
   logic rvalid_r;
   logic rvalid_nxt;

   always_comb begin
      rvalid_nxt = reg_rd;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
      end else if (clk_en) begin
         rvalid_r <= rvalid_nxt;
      end
   end

   assign reg_rdata = rf.rd_data;
   assign reg_rvalid = rvalid_r;

   // Field assembly from the byte store.
   logic [1:0] term_top;
   logic [`FB_WORD_W-1:0] den_word;
   logic [`FB_WORD_W-1:0] rem_word;
   logic [7:0] trunc_field;
   logic [`FB_TERM_W-1:0] term_raw;

   always_comb begin
      term_top = rf.contents[`FB_IDX_FIXED_TERM_TOP*8 +: 2];
      den_word = rf.contents[`FB_IDX_DENOMINATOR_B0*8 +: `FB_WORD_W];
      rem_word = rf.contents[`FB_IDX_REMAINDER_B0*8 +: `FB_WORD_W];
      trunc_field = rf.contents[`FB_IDX_TRUNCATE_POS*8 +: 8];
      term_raw = {term_top, fixed_term_low};
   end

   // The truncation field shapes the term, position and count outputs only when the ratio carries a remainder over a denominator.
   logic frac_form;
   logic [7:0] trunc_eff;
   logic [7:0] trunc_sat;
   logic [7:0] valid_bits;
   logic [FRAC_BITS-1:0] frac_keep_mask;
   logic [`FB_TERM_W-1:0] term_eff;

   always_comb begin
      frac_form = (den_word != `FB_DEN_ONE) || (rem_word != '0);
      trunc_eff = frac_form ? trunc_field : 8'h00;
      // An out-of-range position is clamped so the divider never sees a negative count.
      trunc_sat = (trunc_eff > `FB_TRUNC_MAX) ? `FB_TRUNC_MAX : trunc_eff;
      valid_bits = `FB_TRUNC_MAX - trunc_sat;
      frac_keep_mask = '1;
      for (int b = 0; b < FRAC_BITS; b++) begin
         if (b < int'(trunc_sat)) begin
            frac_keep_mask[b] = 1'b0;
         end
      end
      term_eff = {term_raw[`FB_TERM_W-1 -: INT_BITS], term_raw[FRAC_BITS-1:0] & frac_keep_mask};
   end

   // Consistency checks on what software has programmed.
   fb_ratio_pkg::cfg_status_t status_nxt;

   always_comb begin
      status_nxt.term_zero = (term_raw == '0);
      status_nxt.den_zero = (den_word == '0);
      status_nxt.trunc_invalid = (trunc_field > `FB_TRUNC_MAX);
      status_nxt.den_not_one = (trunc_field == 8'h00) && (den_word != `FB_DEN_ONE);
      status_nxt.rem_not_zero = (trunc_field == 8'h00) && (rem_word != '0);
      status_nxt.low_bits_set = frac_form && ((term_raw[FRAC_BITS-1:0] & ~frac_keep_mask) != '0);
   end

   // Ratio outputs are registered and follow a register write by two cycles.
   logic [`FB_TERM_W-1:0] term_r;
   logic [`FB_TERM_W-1:0] term_nxt;
   logic [`FB_WORD_W-1:0] den_r;
   logic [`FB_WORD_W-1:0] den_nxt;
   logic [`FB_WORD_W-1:0] rem_r;
   logic [`FB_WORD_W-1:0] rem_nxt;
   logic [7:0] trunc_r;
   logic [7:0] trunc_nxt;
   logic [7:0] valid_r;
   logic [7:0] valid_nxt;
   logic form_r;
   logic form_nxt;
   fb_ratio_pkg::cfg_status_t status_r;

   always_comb begin
      term_nxt = term_eff;
      den_nxt = den_word;
      rem_nxt = rem_word;
      trunc_nxt = trunc_sat;
      valid_nxt = valid_bits;
      form_nxt = frac_form;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         term_r <= '0;
         den_r <= `FB_DEN_ONE;
         rem_r <= '0;
         trunc_r <= 8'h00;
         valid_r <= `FB_TRUNC_MAX;
         form_r <= 1'b0;
         status_r <= '0;
      end else if (clk_en) begin
         term_r <= term_nxt;
         den_r <= den_nxt;
         rem_r <= rem_nxt;
         trunc_r <= trunc_nxt;
         valid_r <= valid_nxt;
         form_r <= form_nxt;
         status_r <= status_nxt;
      end
   end

   assign fb_fixed_point_term = term_r;
   assign fb_denominator = den_r;
   assign fb_remainder = rem_r;
   assign fb_truncate_position = trunc_r;
   assign fb_valid_frac_bits = valid_r;
   assign fb_fractional_form = form_r;
   assign cfg_status = status_r;

endmodule : pll_fractional_feedback_regs

`default_nettype wire

// ### verification/fb_regs_asserts.sv
// Port checker for the feedback ratio register bank.
`timescale 1ns/100ps
`default_nettype none
module fb_regs_checker (
   input wire logic clk, // Clock.
   input wire logic rst_n, // Reset.
   input wire logic clk_en, // Enable.
   input wire logic [11:0] reg_addr, // Address.
   input wire logic reg_rd, // Read.
   input wire logic [7:0] reg_rdata, // Read data.
   input wire logic [41:0] fb_fixed_point_term, // Term.
   input wire logic [31:0] fb_denominator, // Denominator.
   input wire logic [31:0] fb_remainder, // Remainder.
   input wire logic [7:0] fb_truncate_position, // Truncation.
   input wire logic [7:0] fb_valid_frac_bits, // Valid bits.
   input wire logic fb_fractional_form, // Form.
   input wire fb_ratio_pkg::cfg_status_t cfg_status // Flags.
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   property p_top; clk_en && reg_rd && reg_addr == 12'h10B |=> reg_rdata[7:2] == 6'h00; endproperty
   a_top: assert property (p_top) else $error("top byte spare bits set");
   property p_vb; fb_valid_frac_bits == 8'h21 - fb_truncate_position; endproperty
   a_vb: assert property (p_vb) else $error("valid bit count wrong");
   property p_tmax; fb_truncate_position <= 8'h21; endproperty
   a_tmax: assert property (p_tmax) else $error("truncation above limit");
   property p_tform; !fb_fractional_form |-> fb_truncate_position == 8'h00; endproperty
   a_tform: assert property (p_tform) else $error("truncation outside fractional form");
   property p_mask; (fb_fixed_point_term & ((42'h1 << fb_truncate_position) - 42'h1)) == 42'h0; endproperty
   a_mask: assert property (p_mask) else $error("truncated bits not cleared");
   property p_den0; cfg_status.den_zero == (fb_denominator == 32'h0); endproperty
   a_den0: assert property (p_den0) else $error("zero denominator flag wrong");
   property p_den1; cfg_status.den_not_one == (fb_truncate_position == 8'h00 && fb_denominator != 32'h1); endproperty
   a_den1: assert property (p_den1) else $error("denominator one flag wrong");
   property p_rem0; cfg_status.rem_not_zero == (fb_truncate_position == 8'h00 && fb_remainder != 32'h0); endproperty
   a_rem0: assert property (p_rem0) else $error("remainder zero flag wrong");
   property p_form; fb_fractional_form == (fb_denominator != 32'h1 || fb_remainder != 32'h0); endproperty
   a_form: assert property (p_form) else $error("fractional form wrong");
   c_frac: cover property (fb_fractional_form && fb_truncate_position == 8'h21);
   c_den1: cover property (cfg_status.den_not_one);
   c_top: cover property (clk_en && reg_rd && reg_addr == 12'h10B);
endmodule : fb_regs_checker
bind pll_fractional_feedback_regs fb_regs_checker u_fb_regs_checker (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fb_fixed_point_term(fb_fixed_point_term),
   .fb_denominator(fb_denominator), .fb_remainder(fb_remainder), .fb_truncate_position(fb_truncate_position),
   .fb_valid_frac_bits(fb_valid_frac_bits), .fb_fractional_form(fb_fractional_form), .cfg_status(cfg_status));
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench of the feedback ratio register bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, reg_rvalid, fb_fractional_form;
   logic [11:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata, fb_truncate_position, fb_valid_frac_bits, f;
   logic [39:0] fixed_term_low = 0;
   logic [41:0] fb_fixed_point_term;
   logic [31:0] fb_denominator, fb_remainder, d, r;
   logic [1:0] top;
   fb_ratio_pkg::cfg_status_t cfg_status;
   int error_cnt = 0, total_checks = 0, k;
   always #4 clk = ~clk;
   pll_fractional_feedback_regs u_pll_fractional_feedback_regs (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .fixed_term_low(fixed_term_low), .fb_fixed_point_term(fb_fixed_point_term),
      .fb_denominator(fb_denominator), .fb_remainder(fb_remainder), .fb_truncate_position(fb_truncate_position),
      .fb_valid_frac_bits(fb_valid_frac_bits), .fb_fractional_form(fb_fractional_form), .cfg_status(cfg_status));
   task automatic give_verdict;
      if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(negedge clk);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge clk);
      reg_wr = 0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(negedge clk);
      reg_rd = 1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 0;
      chk({reg_rvalid, reg_rdata}, {1'b1, e});
      @(negedge clk);
      chk(reg_rvalid, 1'b0);
   endtask : rd
   // Expected ratio outputs follow from the programmed fields and the low term bits.
   task automatic check_out;
      logic frm;
      logic [7:0] t;
      logic [41:0] raw, msk;
      frm = (d != 32'h1) || (r != 32'h0);
      t = !frm ? 8'h00 : (f > 8'h21 ? 8'h21 : f);
      raw = {top, fixed_term_low};
      msk = (42'h1 << t) - 42'h1;
      chk(fb_denominator, d);
      chk(fb_remainder, r);
      chk({fb_truncate_position, fb_valid_frac_bits}, {t, 8'h21 - t});
      chk(fb_fractional_form, frm);
      chk(fb_fixed_point_term, raw & ~msk);
      chk(cfg_status.term_zero, raw == 0);
      chk(cfg_status[4:0], {d == 0, f > 8'h21, f == 0 && d != 1, f == 0 && r != 0, frm && (raw & msk) != 0});
   endtask : check_out
   initial begin
      void'($urandom(32'h4453));
      repeat (16) @(negedge clk);
      rst_n = 1;
      for (int i = 0; i < 10; i++) rd(12'h10B + i, i == 1 ? 8'h01 : 8'h00);
      {top, d, r, f} = {2'h0, 32'h1, 32'h0, 8'h00};
      check_out();
      wr(12'h115, 8'h5A);
      // An address above the bank whose low bits alias the denominator must not land.
      wr(12'h20C, 8'h5A);
      rd(12'h10C, 8'h01);
      rd(12'h115, 8'h00);
      rd(12'h10A, 8'h00);
      wr(12'h10B, 8'hFF);
      rd(12'h10B, 8'h03);
      for (int i = 0; i < 24; i++) begin
         top = $urandom;
         d = $urandom;
         r = $urandom;
         f = $urandom_range(0, 40);
         case (i)
            0: {d, r, f} = {32'h1, 32'h0, 8'h09};
            1: {d, r, f} = {32'h0, 32'h5, 8'h00};
            2: {d, r, f} = {32'h7, 32'h0, 8'h22};
            3: {d, r, f} = {32'h3, 32'h1, 8'h21};
            4: {d, r, f} = {32'h1, 32'h0, 8'h00};
            default: ;
         endcase
         fixed_term_low = {$urandom, $urandom};
         wr(12'h10B, {6'h2A, top});
         for (int j = 0; j < 4; j++) begin
            wr(12'h10C + j, d[8*j+:8]);
            wr(12'h110 + j, r[8*j+:8]);
         end
         wr(12'h114, f);
         repeat (3) @(negedge clk);
         check_out();
         k = $urandom_range(0, 3);
         rd(12'h10C + k, d[8*k+:8]);
         rd(12'h110 + k, r[8*k+:8]);
         rd(12'h114, f);
      end
      // A write with the enable low must leave the register untouched.
      clk_en = 0;
      wr(12'h10C, 8'hAA);
      chk(fb_denominator, d);
      clk_en = 1;
      rd(12'h10C, d[7:0]);
      rst_n = 0;
      @(negedge clk);
      chk(fb_denominator, 32'h1);
      chk({fb_fractional_form, fb_valid_frac_bits}, {1'b0, 8'h21});
      rst_n = 1;
      rd(12'h10C, 8'h01);
      rd(12'h114, 8'h00);
      {top, d, r, f} = {2'h0, 32'h1, 32'h0, 8'h00};
      check_out();
      give_verdict();
   end
   initial begin
      #100000;
      error_cnt++;
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
